/* File: logic/lsm_pkg.sv */
package lsm_pkg;

   // station status codes as seen by software
   typedef enum logic [1:0] {
      LSM_PENDING = 2'b00,
      LSM_LEADER = 2'b01,
      LSM_FOLLOWER = 2'b10,
      LSM_CLASH = 2'b11
   } lsm_status_t;

   // one channel's figures in watts, reported once per mains period
   typedef struct packed {
      logic [31:0] installed;
      logic [31:0] demand;
      logic [31:0] delivered;
   } lsm_chan_t;

   // one event received from the shared link
   typedef struct packed {
      logic announce;
      logic [5:0] addr;
      logic firing;
      logic insert;
   } lsm_link_rx_t;

   // register byte offsets
   localparam logic [7:0] LSM_OFS_CTRL = 8'h00;
   localparam logic [7:0] LSM_OFS_PERIOD = 8'h04;
   localparam logic [7:0] LSM_OFS_SHED = 8'h08;
   localparam logic [7:0] LSM_OFS_STATUS = 8'h0c;
   localparam logic [7:0] LSM_OFS_CHANS = 8'h10;
   localparam logic [7:0] LSM_OFS_INSTALLED = 8'h14;
   localparam logic [7:0] LSM_OFS_DEMANDED = 8'h18;
   localparam logic [7:0] LSM_OFS_DELIVERED = 8'h1c;
   localparam logic [7:0] LSM_OFS_EFFIC = 8'h20;
   localparam logic [7:0] LSM_OFS_LEADER = 8'h24;

   // field positions
   localparam int LSM_CTRL_RESTART_BIT = 8;
   localparam int LSM_STATUS_ALARM_BIT = 2;

   // limits and reset values
   localparam logic [5:0] LSM_ADDR_RST = 6'h00;
   localparam logic [15:0] LSM_PERIOD_MIN = 16'h0032;
   localparam logic [15:0] LSM_PERIOD_MAX = 16'h03e8;
   localparam logic [15:0] LSM_PERIOD_RST = 16'h0032;
   localparam logic [31:0] LSM_SHED_RST = 32'h004c4b40;
   localparam logic [6:0] LSM_CHAN_MAX = 7'h40;
   localparam logic [6:0] LSM_LOWEST_NONE = 7'h40;

   // timing
   localparam longint LSM_CLK_HZ = 64'd40_000_000;
   localparam longint LSM_TIMEOUT_MS = 64'd100;
   localparam longint LSM_TIMEOUT_CYC = (LSM_TIMEOUT_MS * LSM_CLK_HZ) / 64'd1000;
   localparam logic [11:0] LSM_ELECT_WINDOW_CYC = 12'h400;

endpackage

/* File: logic/lsm_top.sv */
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lsm_top #(
   parameter int unsigned TIMEOUT_CYCLES = 32'(lsm_pkg::LSM_TIMEOUT_CYC)
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic MAINS_TICK,
   input wire logic CHAN_VALID,
   input wire lsm_pkg::lsm_chan_t CHAN_DATA,
   input wire lsm_pkg::lsm_link_rx_t LINK_RX,
   output logic LINK_TX_ANNOUNCE,
   output logic [5:0] LINK_TX_ADDR,
   output logic LINK_TX_FIRING,
   output logic [15:0] LINK_TX_PERIOD,
   output logic ALARM_OVER_LIMIT
);
   import lsm_pkg::*;

   logic [5:0] addr_reg;
   logic [15:0] period_reg;
   logic [31:0] shed_reg;
   lsm_status_t status_reg;
   logic [5:0] leader_reg;
   logic [11:0] elect_cnt_reg;
   logic [6:0] lowest_reg;
   logic clash_reg;
   logic [31:0] timeout_cnt_reg;
   logic announce_reg;
   logic [6:0] chan_cnt_reg;
   logic [31:0] inst_acc_reg, dem_acc_reg, del_acc_reg;
   logic [31:0] peak_high_reg, peak_low_reg;
   logic [15:0] mains_cnt_reg;
   logic [6:0] chans_reg;
   logic [31:0] installed_reg, demanded_reg, delivered_reg;
   logic [7:0] effic_reg;
   logic [31:0] prdata_reg;
   logic firing_reg;

   logic wr_en, rd_en, restart_req, timeout_hit, trigger, elect_done, period_end;
   logic [31:0] spread;
   logic [39:0] eff_num;
   logic [39:0] eff_next;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states, unmapped offsets answer with pslverr
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign rd_en = PSEL && !PENABLE && !PWRITE; // setup phase, so data stands at the ready edge
   assign PREADY = 1'b1;
   assign PRDATA = prdata_reg;
   assign restart_req = wr_en && (PADDR == LSM_OFS_CTRL) && PWDATA[LSM_CTRL_RESTART_BIT];
   assign PSLVERR = PSEL && PENABLE && (PADDR > LSM_OFS_LEADER || PADDR[1:0] != 2'b00);

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         addr_reg <= LSM_ADDR_RST;
         period_reg <= LSM_PERIOD_RST;
         shed_reg <= LSM_SHED_RST;
      end else if (wr_en) begin
         if (PADDR == LSM_OFS_CTRL) begin
            addr_reg <= PWDATA[5:0];
         end else if (PADDR == LSM_OFS_PERIOD) begin
            // out-of-range periods are clamped rather than refused
            if (PWDATA[15:0] < LSM_PERIOD_MIN) begin
               period_reg <= LSM_PERIOD_MIN;
            end else if (PWDATA[15:0] > LSM_PERIOD_MAX) begin
               period_reg <= LSM_PERIOD_MAX;
            end else begin
               period_reg <= PWDATA[15:0];
            end
         end else if (PADDR == LSM_OFS_SHED) begin
            shed_reg <= PWDATA;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         prdata_reg <= 32'h0;
      end else if (rd_en) begin
         if (PADDR == LSM_OFS_CTRL) begin
            prdata_reg <= {26'h0, addr_reg};
         end else if (PADDR == LSM_OFS_PERIOD) begin
            prdata_reg <= {16'h0, period_reg};
         end else if (PADDR == LSM_OFS_SHED) begin
            prdata_reg <= shed_reg;
         end else if (PADDR == LSM_OFS_STATUS) begin
            prdata_reg <= {29'h0, ALARM_OVER_LIMIT, status_reg};
         end else if (PADDR == LSM_OFS_CHANS) begin
            prdata_reg <= {25'h0, chans_reg};
         end else if (PADDR == LSM_OFS_INSTALLED) begin
            prdata_reg <= installed_reg;
         end else if (PADDR == LSM_OFS_DEMANDED) begin
            prdata_reg <= demanded_reg;
         end else if (PADDR == LSM_OFS_DELIVERED) begin
            prdata_reg <= delivered_reg;
         end else if (PADDR == LSM_OFS_EFFIC) begin
            prdata_reg <= {24'h0, effic_reg};
         end else if (PADDR == LSM_OFS_LEADER) begin
            prdata_reg <= {26'h0, leader_reg};
         end else begin
            prdata_reg <= 32'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // election
   // a peer announcing outside an election means it was just inserted or restarted
   assign trigger = restart_req || timeout_hit || LINK_RX.insert ||
                    (LINK_RX.announce && elect_cnt_reg == 12'h0 && status_reg != LSM_PENDING);
   assign elect_done = (elect_cnt_reg == 12'h001) && !trigger;
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         status_reg <= LSM_PENDING;
         elect_cnt_reg <= LSM_ELECT_WINDOW_CYC;
         lowest_reg <= LSM_LOWEST_NONE;
         clash_reg <= 1'b0;
         leader_reg <= 6'h00;
         announce_reg <= 1'b1;
      end else if (trigger) begin
         status_reg <= LSM_PENDING;
         elect_cnt_reg <= LSM_ELECT_WINDOW_CYC;
         // an announce that starts or meets a restart still counts as a vote in it
         lowest_reg <= (LINK_RX.announce && LINK_RX.addr != 6'h00) ? {1'b0, LINK_RX.addr} :
                       LSM_LOWEST_NONE;
         clash_reg <= LINK_RX.announce && LINK_RX.addr != 6'h00 && LINK_RX.addr == addr_reg;
         announce_reg <= 1'b1;
      end else begin
         announce_reg <= 1'b0;
         if (elect_cnt_reg != 12'h0) begin
            elect_cnt_reg <= elect_cnt_reg - 12'h001;
         end
         if (elect_cnt_reg != 12'h0 && LINK_RX.announce && LINK_RX.addr != 6'h00) begin
            if (LINK_RX.addr == addr_reg) begin
               clash_reg <= 1'b1;
            end
            if ({1'b0, LINK_RX.addr} < lowest_reg) begin
               lowest_reg <= {1'b0, LINK_RX.addr};
            end
         end
         if (elect_done) begin
            if (addr_reg == 6'h00) begin
               status_reg <= LSM_PENDING;
            end else if (clash_reg || (LINK_RX.announce && LINK_RX.addr == addr_reg)) begin
               status_reg <= LSM_CLASH;
            end else if ({1'b0, addr_reg} < lowest_reg) begin
               status_reg <= LSM_LEADER;
               leader_reg <= addr_reg;
            end else begin
               status_reg <= LSM_FOLLOWER;
               leader_reg <= lowest_reg[5:0];
            end
         end
      end
   end

   assign LINK_TX_ANNOUNCE = announce_reg && addr_reg != 6'h00;
   assign LINK_TX_ADDR = addr_reg;

   // the leader is its own source of firing demands, so it never times out; followers, pending and clash stations with an address do
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         timeout_cnt_reg <= 32'h0;
      end else if (LINK_RX.firing || status_reg == LSM_LEADER || addr_reg == 6'h00 ||
                   trigger) begin
         timeout_cnt_reg <= 32'h0;
      end else begin
         timeout_cnt_reg <= timeout_cnt_reg + 32'h1;
      end
   end

   assign timeout_hit = (timeout_cnt_reg == TIMEOUT_CYCLES - 32'h1);

   ////////////////////////////////////////////////////////////////////////////
   // modulation period and firing demand

   assign period_end = MAINS_TICK && (mains_cnt_reg >= period_reg - 16'h0001);

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         mains_cnt_reg <= 16'h0;
      end else if (period_end) begin
         mains_cnt_reg <= 16'h0;
      end else if (MAINS_TICK) begin
         mains_cnt_reg <= mains_cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         firing_reg <= 1'b0;
      end else begin
         firing_reg <= MAINS_TICK && status_reg == LSM_LEADER;
      end
   end

   assign LINK_TX_FIRING = firing_reg;
   assign LINK_TX_PERIOD = period_reg;

   ////////////////////////////////////////////////////////////////////////////
   // power totals, accumulated over each mains period

   always_ff @(posedge REF_CLK) begin
      if (!RSTN || MAINS_TICK) begin
         chan_cnt_reg <= 7'h0;
         inst_acc_reg <= 32'h0;
         dem_acc_reg <= 32'h0;
         del_acc_reg <= 32'h0;
      end else if (CHAN_VALID && chan_cnt_reg < LSM_CHAN_MAX) begin
         chan_cnt_reg <= chan_cnt_reg + 7'h01;
         inst_acc_reg <= inst_acc_reg + CHAN_DATA.installed;
         dem_acc_reg <= dem_acc_reg + CHAN_DATA.demand;
         del_acc_reg <= del_acc_reg + CHAN_DATA.delivered;
      end
   end

   // peaks of total demand per mains period, restarted every modulation period
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         peak_high_reg <= 32'h0;
         peak_low_reg <= 32'hffffffff;
      end else if (period_end) begin
         peak_high_reg <= 32'h0;
         peak_low_reg <= 32'hffffffff;
      end else if (MAINS_TICK) begin
         if (dem_acc_reg > peak_high_reg) begin
            peak_high_reg <= dem_acc_reg;
         end
         if (dem_acc_reg < peak_low_reg) begin
            peak_low_reg <= dem_acc_reg;
         end
      end
   end

   always_comb begin
      spread = (dem_acc_reg > peak_high_reg ? dem_acc_reg : peak_high_reg) -
               (dem_acc_reg < peak_low_reg ? dem_acc_reg : peak_low_reg);
      eff_num = (spread > inst_acc_reg) ? 40'h0 :
                40'(inst_acc_reg - spread) * 40'd100;
      eff_next = (inst_acc_reg == 32'h0) ? 40'h0 : eff_num / {8'h0, inst_acc_reg};
   end

   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         chans_reg <= 7'h0;
         installed_reg <= 32'h0;
         demanded_reg <= 32'h0;
         delivered_reg <= 32'h0;
         effic_reg <= 8'h0;
      end else if (period_end) begin
         chans_reg <= chan_cnt_reg;
         installed_reg <= inst_acc_reg;
         demanded_reg <= dem_acc_reg;
         delivered_reg <= del_acc_reg;
         effic_reg <= eff_next[7:0];
      end
   end

   // combinational so the alarm drops the moment leadership is lost
   assign ALARM_OVER_LIMIT = (status_reg == LSM_LEADER) && (delivered_reg > shed_reg);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   localparam int win_c = 1025; // election window plus the cycle that resolves it
   logic rst_q;
   always_ff @(posedge REF_CLK) begin
      rst_q <= !RSTN;
   end
   property p_alarm_leader_only;
      @(posedge REF_CLK) disable iff (!RSTN)
      ALARM_OVER_LIMIT |-> status_reg == LSM_LEADER && delivered_reg > shed_reg;
   endproperty
   a_alarm_leader_only: assert property (p_alarm_leader_only) else $error("alarm off leader");
   property p_alarm_raise;
      @(posedge REF_CLK) disable iff (!RSTN)
      (status_reg == LSM_LEADER && delivered_reg > shed_reg) |-> ALARM_OVER_LIMIT;
   endproperty
   a_alarm_raise: assert property (p_alarm_raise) else $error("alarm missing");
   property p_trigger_pending;
      @(posedge REF_CLK) disable iff (!RSTN)
      trigger |=> status_reg == LSM_PENDING && elect_cnt_reg == LSM_ELECT_WINDOW_CYC;
   endproperty
   a_trigger_pending: assert property (p_trigger_pending) else $error("no restart");
   property p_insert_elect;
      @(posedge REF_CLK) disable iff (!RSTN)
      LINK_RX.insert |=> LINK_TX_ANNOUNCE || addr_reg == 6'h00;
   endproperty
   a_insert_elect: assert property (p_insert_elect) else $error("insert ignored");
   property p_resolve_bound;
      @(posedge REF_CLK) disable iff (!RSTN)
      (trigger ##1 !trigger [*1]) |-> ##[0:win_c] (status_reg != LSM_PENDING || trigger ||
                                                   addr_reg == 6'h00 || elect_cnt_reg == 12'h0);
   endproperty
   a_resolve_bound: assert property (p_resolve_bound) else $error("election stuck");
   property p_leader_addr;
      @(posedge REF_CLK) disable iff (!RSTN)
      $rose(status_reg == LSM_LEADER) |-> leader_reg == addr_reg && addr_reg != 6'h00;
   endproperty
   a_leader_addr: assert property (p_leader_addr) else $error("leader address wrong");
   property p_follower_addr;
      @(posedge REF_CLK) disable iff (!RSTN)
      $rose(status_reg == LSM_FOLLOWER) |-> leader_reg < addr_reg;
   endproperty
   a_follower_addr: assert property (p_follower_addr) else $error("follower not higher");
   property p_zero_addr;
      @(posedge REF_CLK) disable iff (!RSTN)
      (addr_reg == 6'h00 && $past(addr_reg) == 6'h00) |-> status_reg == LSM_PENDING ||
                                                        status_reg == $past(status_reg);
   endproperty
   a_zero_addr: assert property (p_zero_addr) else $error("zero address elected");
   property p_timeout;
      @(posedge REF_CLK) disable iff (!RSTN)
      timeout_hit |=> status_reg == LSM_PENDING && timeout_cnt_reg == 32'h0;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout no election");
   property p_totals_hold;
      @(posedge REF_CLK) disable iff (!RSTN)
      !$past(period_end) && !rst_q |-> $stable(effic_reg) && $stable(delivered_reg);
   endproperty
   a_totals_hold: assert property (p_totals_hold) else $error("totals moved");
   property p_effic_range;
      @(posedge REF_CLK) disable iff (!RSTN)
      effic_reg <= 8'h64 && chans_reg <= LSM_CHAN_MAX;
   endproperty
   a_effic_range: assert property (p_effic_range) else $error("efficiency or count out of range");
   c_leader: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(status_reg == LSM_LEADER));
   c_follower: cover property (@(posedge REF_CLK) disable iff (!RSTN)
                               $rose(status_reg == LSM_FOLLOWER));
   c_clash: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(status_reg == LSM_CLASH));
   c_alarm: cover property (@(posedge REF_CLK) disable iff (!RSTN) $rose(ALARM_OVER_LIMIT));
endmodule

`default_nettype wire

/* File: test/lsm_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none

// peers that answer every election call and, when asked, act as a firing leader
module lsm_peer_model
   import lsm_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic tx_announce,
   input wire logic [5:0] peer_a,
   input wire logic [5:0] peer_b,
   input wire logic [7:0] reply_delay,
   input wire logic fire_en,
   input wire logic insert_req,
   output lsm_link_rx_t rx
);
   int wait_cnt = -1;
   int fire_cnt = 0;

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (!rstn) begin
         wait_cnt <= -1;
         fire_cnt <= 0;
         rx <= '0;
      end else begin
         rx.insert <= insert_req;
         if (tx_announce === 1'b1) begin
            wait_cnt <= int'(reply_delay);
         end else if (wait_cnt >= 0) begin
            wait_cnt <= wait_cnt - 1;
         end
         if (wait_cnt == 1 && peer_a != 6'h00) begin
            rx.announce <= 1'b1;
            rx.addr <= peer_a;
         end else if (wait_cnt == 0 && peer_b != 6'h00) begin
            rx.announce <= 1'b1;
            rx.addr <= peer_b;
         end else begin
            rx.announce <= 1'b0;
            // no pull on the link: an idle address shows its inverse, never a stale vote
            rx.addr <= ~rx.addr;
         end
         fire_cnt <= (fire_cnt == 99) ? 0 : fire_cnt + 1;
         rx.firing <= fire_en && fire_cnt == 99;
      end
   end
endmodule

`default_nettype wire

/* File: test/test_lsm_top.sv */
`timescale 1ns/1ps
`default_nettype none

module test_lsm_top;
   import lsm_pkg::*;
   // timeout kept above the election window so pending never retriggers itself
   localparam int TMO = 3000;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic mains_tick = 1'b0;
   logic chan_valid = 1'b0;
   lsm_chan_t chan_data = '0;
   lsm_link_rx_t link_rx;
   logic tx_ann;
   logic [5:0] tx_addr;
   logic tx_fire;
   logic [15:0] tx_period;
   logic alarm;
   logic [5:0] peer_a = 6'h00;
   logic [5:0] peer_b = 6'h00;
   logic [7:0] reply_delay = 8'h03;
   logic fire_en = 1'b0;
   logic insert_req = 1'b0;
   int err_count = 0;
   int checks_done = 0;
   int ann_seen = 0;
   int fire_seen = 0;

   initial begin
      forever #12.5 clk = ~clk;
   end

   lsm_top #(.TIMEOUT_CYCLES(TMO)) u_lsm_top (
      .REF_CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .MAINS_TICK(mains_tick), .CHAN_VALID(chan_valid),
      .CHAN_DATA(chan_data), .LINK_RX(link_rx), .LINK_TX_ANNOUNCE(tx_ann),
      .LINK_TX_ADDR(tx_addr), .LINK_TX_FIRING(tx_fire), .LINK_TX_PERIOD(tx_period),
      .ALARM_OVER_LIMIT(alarm)
   );

   lsm_peer_model u_lsm_peer_model (
      .clk(clk), .rstn(rstn), .tx_announce(tx_ann), .peer_a(peer_a), .peer_b(peer_b),
      .reply_delay(reply_delay), .fire_en(fire_en), .insert_req(insert_req), .rx(link_rx)
   );

   always @(posedge clk) begin
      if (tx_ann === 1'b1) begin
         ann_seen++;
      end
      if (tx_fire === 1'b1) begin
         fire_seen++;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // read data and error are taken at the edge where pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         err_count++;
         $display("[FAIL] pready expected 1 seen %0b", pready);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h00000000, r, e);
      chk(what, exp, r);
   endtask

   task automatic elect(input logic [5:0] a);
      wr(LSM_OFS_CTRL, {23'h000000, 1'b1, 2'b00, a});
   endtask

   task automatic chan(input logic [31:0] dem);
      chan_valid <= 1'b1;
      chan_data <= {32'h000003e8, dem, 32'h00000258};
      @(posedge clk);
      chan_valid <= 1'b0;
      @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] r;
      logic e;
      rd_chk("status", LSM_OFS_STATUS, 32'h00000000);
      rd_chk("ctrl", LSM_OFS_CTRL, 32'h00000000);
      rd_chk("period", LSM_OFS_PERIOD, {16'h0000, LSM_PERIOD_RST});
      rd_chk("shed", LSM_OFS_SHED, LSM_SHED_RST);
      apb(1'b0, 8'h28, 32'h00000000, r, e);
      chk("unmapped", 32'h00000001, {31'h00000000, e});
      cyc(1100);
      rd_chk("zero addr status", LSM_OFS_STATUS, 32'h00000000);
      chk("zero addr announces", 32'h00000000, ann_seen);
      $display("test reset done");
   endtask

   task automatic t_leader;
      peer_a <= 6'h09;
      peer_b <= 6'h0c;
      wr(LSM_OFS_CTRL, 32'h00000005);
      elect(6'h05);
      cyc(5);
      rd_chk("electing", LSM_OFS_STATUS, 32'h00000000);
      cyc(1100);
      rd_chk("leader", LSM_OFS_STATUS, 32'h00000001);
      rd_chk("leader addr", LSM_OFS_LEADER, 32'h00000005);
      chk("tx addr", 32'h00000005, {26'h0000000, tx_addr});
      elect(6'h05);
      cyc(600);
      elect(6'h05);
      cyc(600);
      rd_chk("restarted", LSM_OFS_STATUS, 32'h00000000);
      cyc(500);
      rd_chk("re-leader", LSM_OFS_STATUS, 32'h00000001);
      chk("announces", 32'h00000003, ann_seen);
      $display("test leader done");
   endtask

   task automatic t_power;
      wr(LSM_OFS_PERIOD, 32'h000007d0);
      rd_chk("period high", LSM_OFS_PERIOD, 32'h000003e8);
      chk("tx period", 32'h000003e8, {16'h0000, tx_period});
      wr(LSM_OFS_PERIOD, 32'h00000014);
      rd_chk("period low", LSM_OFS_PERIOD, 32'h00000032);
      wr(LSM_OFS_SHED, 32'h000003e8);
      fire_seen = 0;
      // demand sum alternates 800/1300 so any window sees a spread of 500
      for (int i = 0; i < 150; i++) begin
         chan(32'h00000190);
         chan((i % 2) ? 32'h00000384 : 32'h00000190);
         mains_tick <= 1'b1;
         @(posedge clk);
         mains_tick <= 1'b0;
         cyc(2);
      end
      cyc(3);
      chk("firing", 32'h00000096, fire_seen);
      rd_chk("channels", LSM_OFS_CHANS, 32'h00000002);
      rd_chk("installed", LSM_OFS_INSTALLED, 32'h000007d0);
      rd_chk("delivered", LSM_OFS_DELIVERED, 32'h000004b0);
      rd_chk("efficiency", LSM_OFS_EFFIC, 32'h0000004b);
      // the mains period that closed the run demanded 400 + 900 watts
      rd_chk("demanded", LSM_OFS_DEMANDED, 32'h00000514);
      rd_chk("alarm on", LSM_OFS_STATUS, 32'h00000005);
      chk("alarm pin", 32'h00000001, {31'h00000000, alarm});
      wr(LSM_OFS_SHED, 32'h000004b0);
      rd_chk("alarm at limit", LSM_OFS_STATUS, 32'h00000001);
      rd_chk("delivered held", LSM_OFS_DELIVERED, 32'h000004b0);
      $display("test power done");
   endtask

   task automatic t_follower;
      wr(LSM_OFS_SHED, 32'h000003e8);
      peer_a <= 6'h03;
      fire_en <= 1'b1;
      reply_delay <= 8'hc8;
      elect(6'h05);
      cyc(1100);
      rd_chk("follower", LSM_OFS_STATUS, 32'h00000002);
      chk("alarm pin", 32'h00000000, {31'h00000000, alarm});
      rd_chk("leader addr", LSM_OFS_LEADER, 32'h00000003);
      fire_en <= 1'b0;
      cyc(2850);
      rd_chk("before timeout", LSM_OFS_STATUS, 32'h00000002);
      cyc(300);
      rd_chk("after timeout", LSM_OFS_STATUS, 32'h00000000);
      fire_en <= 1'b1;
      cyc(1100);
      rd_chk("follower again", LSM_OFS_STATUS, 32'h00000002);
      $display("test follower done");
   endtask

   task automatic t_insert_clash;
      insert_req <= 1'b1;
      @(posedge clk);
      insert_req <= 1'b0;
      cyc(5);
      rd_chk("insert pending", LSM_OFS_STATUS, 32'h00000000);
      cyc(1100);
      rd_chk("insert done", LSM_OFS_STATUS, 32'h00000002);
      peer_a <= 6'h05;
      elect(6'h05);
      cyc(1100);
      rd_chk("clash", LSM_OFS_STATUS, 32'h00000003);
      $display("test insert and clash done");
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(8);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_leader();
      t_power();
      t_follower();
      t_insert_clash();
      give_verdict();
   end

   // whole run is near 12600 cycles
   initial begin
      cyc(40000);
      err_count++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule

`default_nettype wire
